// File: rtl/flash_status_register.sv
// Operation
// - Opcode 05h after select starts status output one bit per clock.
// - Readout sends byte one then byte two, then repeats from byte one.
// - Status read accepted anytime; each pass shows live values.
// - Deselect anywhere ends the read and releases the serial output.
// - Lock bit with write-protect asserted freezes array protection; lock resets 0.
// - Lock changes freely when pin deasserted; only 0 to 1 when asserted.
// - Write-status alters only byte one bits 7 and 2.
// - Error flag updated after each erase or program; 1 on failure.
// - Aborted erase or program never sets the error flag.
// - Byte one bit 4 mirrors write-protect pin, 0 when asserted.
// - Array protection bit 1 refuses program and erase on whole array.
// - Latch clear rejects program, erase, register program and status writes.
// - Write enable latch clears at power-up and at a device reset granted while reset-enable is set.
// - Latch clears after write disable, modifying operations, or hold abort.
// - Incomplete or unknown opcode abort leaves a set latch alone.
// - Busy flag 1 during internal operation, at bit 0 of both bytes.
// - Byte two bit 4 enables software reset; 0 after power-up.
// - Reset-enable bit changes only by second-byte write or power cycle.
// - Opcode 01h plus data byte writes lock and protection at deselect.
// - Opcode 31h plus data byte writes reset-enable at deselect.
// - Short or misaligned status write aborts, bits kept, latch cleared.
// - Clearing lock while pin asserted is ignored and clears the latch.
`timescale 1ns/1ps
`include "fsr_map.svh"
module flash_status_register (
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic       sclk_pin,
	input  wire logic       cs_n_pin,
	input  wire logic       si_pin,
	input  wire logic       wp_n_pin,
	output logic            so_out,
	output logic            so_oe_n,
	input  wire logic       core_busy,
	input  wire logic       core_op_done,
	input  wire logic       core_op_fail,
	input  wire logic       core_op_abort,
	input  wire logic       core_hold_abort,
	input  wire logic       core_dev_reset,
	output logic [7:0]      opcode_out,
	output logic            opcode_valid,
	output logic            write_enable_latch,
	output logic            array_protect,
	output logic            protection_lock,
	output logic            reset_cmd_enable,
	output logic            array_write_ok,
	output logic            dev_reset_grant
);
	fsr_link_if lnk ();

	fsr_spi_front #(
		.SYNC_DEPTH(`FSR_SYNC_DEPTH)
	) u_front (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.sclk_pin (sclk_pin),
		.cs_n_pin (cs_n_pin),
		.si_pin   (si_pin),
		.wp_n_pin (wp_n_pin),
		.lnk      (lnk.front)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	fsr_pkg::fsr_phase_t phase_reg;
	fsr_pkg::fsr_phase_t phase_next;
	logic       lock_reg;
	logic       lock_next;
	logic       prot_reg;
	logic       prot_next;
	logic       err_reg;
	logic       err_next;
	logic       wel_reg;
	logic       wel_next;
	logic       reset_cmd_enable_reg;
	logic       reset_cmd_enable_next;
	logic       second_reg;
	logic       cmd2_reg;
	logic       data_seen_reg;
	logic [7:0] wdata_reg;
	logic [7:0] opcode_reg;
	logic       opcode_valid_reg;
	logic       so_oe_n_reg;

	// ----------------------------------------------------------------
	// Live status bytes
	// ----------------------------------------------------------------
	wire       wp_asserted = ~lnk.wp_n;
	wire [7:0] status_one;
	wire [7:0] status_two;

	assign status_one[`FSR_B1_LOCK] = lock_reg;
	assign status_one[6]            = `FSR_RES_VAL;
	assign status_one[`FSR_B1_ERR]  = err_reg;
	assign status_one[`FSR_B1_PIN]  = lnk.wp_n;
	assign status_one[3]            = `FSR_RES_VAL;
	assign status_one[`FSR_B1_PROT] = prot_reg;
	assign status_one[`FSR_B1_WEL]  = wel_reg;
	assign status_one[`FSR_B1_BUSY] = core_busy;

	// ----------------------------------------------------------------
	// Byte two
	// ----------------------------------------------------------------
	assign status_two[7:5]          = {3{`FSR_RES_VAL}};
	assign status_two[`FSR_B2_RESET_CMD_ENABLE] = reset_cmd_enable_reg;
	assign status_two[3:1]          = {3{`FSR_RES_VAL}};
	assign status_two[`FSR_B2_BUSY] = core_busy;

	// Byte picked at load time so each pass is live
	assign lnk.tx_byte = second_reg ? status_two : status_one;

	// ----------------------------------------------------------------
	// Opcode decode
	// ----------------------------------------------------------------
	wire op_rd   = (lnk.rx_byte == `FSR_OP_READ_STATUS);
	wire op_ws1  = (lnk.rx_byte == `FSR_OP_WRITE_STATUS);
	wire op_ws2  = (lnk.rx_byte == `FSR_OP_WRITE_STATUS2);
	wire op_wen  = (lnk.rx_byte == `FSR_OP_WRITE_ENABLE);
	wire op_wdis = (lnk.rx_byte == `FSR_OP_WRITE_DISABLE);
	wire opc_byte = lnk.byte_done & (phase_reg == fsr_pkg::FSR_PH_OPCODE);

	always_comb begin
		phase_next = phase_reg;
		case (phase_reg)
			fsr_pkg::FSR_PH_IDLE: begin
				if (lnk.sel) begin
					phase_next = fsr_pkg::FSR_PH_OPCODE;
				end
			end
			fsr_pkg::FSR_PH_OPCODE: begin
				if (lnk.byte_done) begin
					if (op_rd) begin
						phase_next = fsr_pkg::FSR_PH_READ;
					end else if (op_ws1 | op_ws2) begin
						phase_next = fsr_pkg::FSR_PH_WDATA;
					end else if (op_wen) begin
						phase_next = fsr_pkg::FSR_PH_WEN;
					end else if (op_wdis) begin
						phase_next = fsr_pkg::FSR_PH_WDIS;
					end else begin
						phase_next = fsr_pkg::FSR_PH_OTHER;
					end
				end
			end
			fsr_pkg::FSR_PH_READ,
			fsr_pkg::FSR_PH_WDATA,
			fsr_pkg::FSR_PH_WEN,
			fsr_pkg::FSR_PH_WDIS,
			fsr_pkg::FSR_PH_OTHER: begin
				phase_next = phase_reg;
			end
			default: begin
				phase_next = fsr_pkg::FSR_PH_IDLE;
			end
		endcase
		if (!lnk.sel) begin
			phase_next = fsr_pkg::FSR_PH_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// Status write evaluation at deselect
	// ----------------------------------------------------------------
	wire end_wdata  = lnk.frame_end & (phase_reg == fsr_pkg::FSR_PH_WDATA);
	wire wr_good    = end_wdata & wel_reg & data_seen_reg & lnk.aligned;
	wire lock_held  = lock_reg & wp_asserted;
	wire lock_clear = lock_held & ~wdata_reg[`FSR_B1_LOCK];
	wire apply_one  = wr_good & ~cmd2_reg & ~lock_clear;
	wire apply_two  = wr_good & cmd2_reg;
	wire soft_reset = core_dev_reset & reset_cmd_enable_reg;

	always_comb begin
		lock_next = lock_reg;
		prot_next = prot_reg;
		reset_cmd_enable_next = reset_cmd_enable_reg;
		if (apply_one) begin
			lock_next = wdata_reg[`FSR_B1_LOCK];
			if (!lock_held) begin
				prot_next = wdata_reg[`FSR_B1_PROT];
			end
		end
		if (apply_two) begin
			reset_cmd_enable_next = wdata_reg[`FSR_B2_RESET_CMD_ENABLE];
		end
	end

	// ----------------------------------------------------------------
	// Write enable latch and error flag
	// ----------------------------------------------------------------
	wire in_wen     = (phase_reg == fsr_pkg::FSR_PH_WEN);
	wire in_wdis    = (phase_reg == fsr_pkg::FSR_PH_WDIS);
	wire clean_end  = lnk.frame_end & lnk.aligned;
	wire wen_done   = clean_end & in_wen;
	wire wdis_done  = clean_end & in_wdis;
	wire engine_end = core_op_done | core_op_abort | core_hold_abort;
	wire wel_set    = wen_done;
	wire wel_clr    = wdis_done
		| end_wdata
		| engine_end
		| soft_reset;

	// Set wins over a same-cycle clear; opcode-phase aborts never clear
	assign wel_next = wel_set ? 1'h1 : (wel_clr ? 1'h0 : wel_reg);
	assign err_next = core_op_done ? core_op_fail : err_reg;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			phase_reg <= fsr_pkg::FSR_PH_IDLE;
			lock_reg  <= `FSR_LOCK_RST;
			prot_reg  <= `FSR_PROT_RST;
			err_reg   <= `FSR_ERR_RST;
			wel_reg   <= `FSR_WEL_RST;
			reset_cmd_enable_reg  <= `FSR_RESET_CMD_ENABLE_RST;
		end else begin
			phase_reg <= phase_next;
			lock_reg  <= lock_next;
			prot_reg  <= prot_next;
			err_reg   <= err_next;
			wel_reg   <= wel_next;
			reset_cmd_enable_reg  <= reset_cmd_enable_next;
		end
	end

	// ----------------------------------------------------------------
	// Readout byte alternation
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			second_reg <= 1'h0;
		end else if (phase_reg != fsr_pkg::FSR_PH_READ) begin
			second_reg <= 1'h0;
		end else if (lnk.byte_done) begin
			second_reg <= ~second_reg;
		end
	end

	// Data byte capture; bytes after the first are ignored
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cmd2_reg      <= 1'h0;
			data_seen_reg <= 1'h0;
			wdata_reg     <= 8'h00;
		end else if (opc_byte) begin
			cmd2_reg      <= op_ws2;
			data_seen_reg <= 1'h0;
		end else if (lnk.byte_done & (phase_reg == fsr_pkg::FSR_PH_WDATA) & ~data_seen_reg) begin
			wdata_reg     <= lnk.rx_byte;
			data_seen_reg <= 1'h1;
		end
	end

	// Opcode hand-off to the array engine
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			opcode_reg       <= 8'h00;
			opcode_valid_reg <= 1'h0;
		end else begin
			opcode_valid_reg <= opc_byte;
			if (opc_byte) begin
				opcode_reg <= lnk.rx_byte;
			end
		end
	end

	// Serial output drive, released on deselect
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			so_oe_n_reg <= 1'h1;
		end else begin
			so_oe_n_reg <= ~(phase_next == fsr_pkg::FSR_PH_READ);
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign so_out             = lnk.tx_bit;
	assign so_oe_n            = so_oe_n_reg;

	// ----------------------------------------------------------------
	// Array engine side
	// ----------------------------------------------------------------
	assign opcode_out         = opcode_reg;
	assign opcode_valid       = opcode_valid_reg;
	assign write_enable_latch = wel_reg;
	assign array_protect      = prot_reg;
	assign protection_lock    = lock_reg;
	assign reset_cmd_enable   = reset_cmd_enable_reg;
	assign array_write_ok     = wel_reg & ~prot_reg;
	assign dev_reset_grant    = soft_reset;
endmodule

// File: rtl/fsr_link_if.sv
`timescale 1ns/1ps
interface fsr_link_if;
	logic       sel;
	logic       byte_done;
	logic [7:0] rx_byte;
	logic       frame_end;
	logic       aligned;
	logic       wp_n;
	logic [7:0] tx_byte;
	logic       tx_bit;

	modport front (
		output sel,
		output byte_done,
		output rx_byte,
		output frame_end,
		output aligned,
		output wp_n,
		output tx_bit,
		input  tx_byte
	);

	modport core (
		input  sel,
		input  byte_done,
		input  rx_byte,
		input  frame_end,
		input  aligned,
		input  wp_n,
		input  tx_bit,
		output tx_byte
	);
endinterface

// File: rtl/fsr_map.svh
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define FSR_OP_READ_STATUS   8'h05
`define FSR_OP_WRITE_STATUS  8'h01
`define FSR_OP_WRITE_STATUS2 8'h31
`define FSR_OP_WRITE_ENABLE  8'h06
`define FSR_OP_WRITE_DISABLE 8'h04

// ----------------------------------------------------------------
// Status byte one field positions
// ----------------------------------------------------------------
`define FSR_B1_LOCK 7
`define FSR_B1_ERR  5
`define FSR_B1_PIN  4
`define FSR_B1_PROT 2
`define FSR_B1_WEL  1
`define FSR_B1_BUSY 0

// ----------------------------------------------------------------
// Status byte two field positions
// ----------------------------------------------------------------
`define FSR_B2_RESET_CMD_ENABLE 4
`define FSR_B2_BUSY 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FSR_LOCK_RST 1'h0
`define FSR_PROT_RST 1'h0
`define FSR_ERR_RST  1'h0
`define FSR_WEL_RST  1'h0
`define FSR_RESET_CMD_ENABLE_RST 1'h0
`define FSR_RES_VAL  1'h0

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define FSR_SYNC_DEPTH 2

`endif

// File: rtl/fsr_pkg.sv
package fsr_pkg;

	typedef enum logic [2:0] {
		FSR_PH_IDLE   = 3'h0,
		FSR_PH_OPCODE = 3'h1,
		FSR_PH_READ   = 3'h2,
		FSR_PH_WDATA  = 3'h3,
		FSR_PH_WEN    = 3'h4,
		FSR_PH_WDIS   = 3'h5,
		FSR_PH_OTHER  = 3'h6
	} fsr_phase_t;

endpackage

// File: rtl/fsr_spi_front.sv
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_spi_front #(
	parameter int SYNC_DEPTH = `FSR_SYNC_DEPTH
) (
	input  wire logic clk_sys,
	input  wire logic nrst,
	input  wire logic sclk_pin,
	input  wire logic cs_n_pin,
	input  wire logic si_pin,
	input  wire logic wp_n_pin,
	fsr_link_if.front lnk
);
	generate
		if (SYNC_DEPTH < 2) begin : g_bad_depth
			$error("SYNC_DEPTH must be at least 2");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pin_raw;
	logic [3:0] pin_sync;
	assign pin_raw = {wp_n_pin, si_pin, cs_n_pin, sclk_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			logic [SYNC_DEPTH-1:0] chain_reg;
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					// Idle levels: select and write-protect high
					chain_reg <= {SYNC_DEPTH{(gi == 1) || (gi == 3)}};
				end else begin
					chain_reg <= {chain_reg[SYNC_DEPTH-2:0], pin_raw[gi]};
				end
			end
			assign pin_sync[gi] = chain_reg[SYNC_DEPTH-1];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Edge detection
	// ----------------------------------------------------------------
	logic       sclk_d_reg;
	logic       cs_n_d_reg;
	logic [2:0] bit_cnt_reg;
	logic [6:0] rx_sh_reg;
	logic [7:0] rx_byte_reg;
	logic       byte_done_reg;
	logic       load_pend_reg;
	logic [7:0] tx_sh_reg;
	wire        sel_w  = ~pin_sync[1];
	wire        rise_w = sel_w & pin_sync[0] & ~sclk_d_reg;
	wire        fall_w = sel_w & ~pin_sync[0] & sclk_d_reg;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sclk_d_reg <= 1'h0;
			cs_n_d_reg <= 1'h1;
		end else begin
			sclk_d_reg <= pin_sync[0];
			cs_n_d_reg <= pin_sync[1];
		end
	end

	// ----------------------------------------------------------------
	// Receive shifter, MSB first on rising clock
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bit_cnt_reg   <= 3'h0;
			rx_sh_reg     <= 7'h00;
			rx_byte_reg   <= 8'h00;
			byte_done_reg <= 1'h0;
		end else begin
			byte_done_reg <= rise_w & (bit_cnt_reg == 3'h7);
			if (!sel_w) begin
				bit_cnt_reg <= 3'h0;
			end else if (rise_w) begin
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				rx_sh_reg   <= {rx_sh_reg[5:0], pin_sync[2]};
				if (bit_cnt_reg == 3'h7) begin
					rx_byte_reg <= {rx_sh_reg, pin_sync[2]};
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit shifter, new byte loaded on first falling clock after a byte
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			load_pend_reg <= 1'h0;
			tx_sh_reg     <= 8'h00;
		end else if (!sel_w) begin
			load_pend_reg <= 1'h0;
			tx_sh_reg     <= 8'h00;
		end else begin
			if (byte_done_reg) begin
				load_pend_reg <= 1'h1;
			end else if (fall_w) begin
				load_pend_reg <= 1'h0;
			end
			if (fall_w) begin
				tx_sh_reg <= load_pend_reg ? lnk.tx_byte : {tx_sh_reg[6:0], 1'h0};
			end
		end
	end

	assign lnk.sel       = sel_w;
	assign lnk.byte_done = byte_done_reg;
	assign lnk.rx_byte   = rx_byte_reg;
	assign lnk.frame_end = pin_sync[1] & ~cs_n_d_reg;
	assign lnk.aligned   = (bit_cnt_reg == 3'h0);
	assign lnk.wp_n      = pin_sync[3];
	assign lnk.tx_bit    = tx_sh_reg[7];
endmodule

// File: test/fsr_checker.sv
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_checker (
	input wire logic       clk_sys,
	input wire logic       nrst,
	input wire logic       cs_n_pin,
	input wire logic       wp_n_pin,
	input wire logic       so_oe_n,
	input wire logic       core_op_done,
	input wire logic       core_op_abort,
	input wire logic       core_hold_abort,
	input wire logic       core_dev_reset,
	input wire logic [7:0] opcode_out,
	input wire logic       opcode_valid,
	input wire logic       write_enable_latch,
	input wire logic       array_protect,
	input wire logic       protection_lock,
	input wire logic       reset_cmd_enable,
	input wire logic       array_write_ok,
	input wire logic       dev_reset_grant
);
	// ----------
	// Port rules
	// ----------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	AST_GRANT: assert property (dev_reset_grant == (core_dev_reset & reset_cmd_enable))
		else $error("reset grant wrong");
	AST_WOK: assert property (array_write_ok == (write_enable_latch & ~array_protect))
		else $error("array permit wrong");
	AST_END: assert property (core_op_done | core_op_abort | core_hold_abort |=> !write_enable_latch)
		else $error("latch kept after operation end");
	AST_DEVRST: assert property (dev_reset_grant |=> !write_enable_latch && $stable(reset_cmd_enable))
		else $error("software reset effect wrong");
	AST_RESET_CMD_ENABLE: assert property ($changed(reset_cmd_enable) |-> opcode_out == `FSR_OP_WRITE_STATUS2)
		else $error("reset enable changed by other command");
	AST_PROT: assert property ($changed(array_protect) || $changed(protection_lock)
		|-> opcode_out == `FSR_OP_WRITE_STATUS)
		else $error("protection changed by other command");
	AST_FROZEN: assert property (!wp_n_pin && !$past(wp_n_pin, 4) && $past(protection_lock)
		|-> protection_lock && $stable(array_protect))
		else $error("locked protection changed");
	AST_WEL_SET: assert property ($rose(write_enable_latch) |-> opcode_out == `FSR_OP_WRITE_ENABLE)
		else $error("latch set by other command");
	AST_OE_IDLE: assert property (cs_n_pin [*6] |-> so_oe_n)
		else $error("output driven while deselected");
	AST_OE_READ: assert property (opcode_valid && opcode_out == `FSR_OP_READ_STATUS
		|-> ##[0:6] !so_oe_n)
		else $error("status output not enabled");
endmodule

bind flash_status_register fsr_checker u_fsr_checker (
	.clk_sys, .nrst, .cs_n_pin, .wp_n_pin, .so_oe_n, .core_op_done, .core_op_abort,
	.core_hold_abort, .core_dev_reset, .opcode_out, .opcode_valid, .write_enable_latch,
	.array_protect, .protection_lock, .reset_cmd_enable, .array_write_ok, .dev_reset_grant
);

// File: test/fsr_host_model.sv
`timescale 1ns/1ps
module fsr_host_model (
	input  wire logic clk_sys,
	output logic      sclk,
	output logic      cs_n,
	output logic      si,
	input  wire logic so,
	input  wire logic so_oe_n
);
	// ----------
	// Mode 0 host
	// ----------
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si   = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic sel();
		tick(4);
		cs_n = 1'b0;
		tick(4);
	endtask

	// Sample at end of high phase, before the falling edge
	task automatic xbit(input logic b, output logic r);
		si = b;
		tick(4);
		sclk = 1'b1;
		tick(4);
		r = so_oe_n ? 1'bx : so;
		sclk = 1'b0;
	endtask

	// Ends the frame right after the last bit sent, whether or not on a byte boundary
	task automatic desel();
		tick(4);
		cs_n = 1'b1;
		si = ~si;
		tick(12);
	endtask
endmodule

// File: test/tb_flash_status_register.sv
`timescale 1ns/1ps
`include "fsr_map.svh"
module tb_flash_status_register;
	logic        clk_sys = 1'b0;
	logic        nrst;
	logic        wp_n_pin;
	logic        core_busy;
	logic        core_op_done;
	logic        core_op_fail;
	logic        core_op_abort;
	logic        core_hold_abort;
	logic        core_dev_reset;
	logic        sclk;
	logic        cs_n;
	logic        si;
	logic        so_out;
	logic        so_oe_n;
	logic [7:0]  opcode_out;
	logic        opcode_valid;
	logic        write_enable_latch;
	logic        array_protect;
	logic        protection_lock;
	logic        reset_cmd_enable;
	logic        array_write_ok;
	logic        dev_reset_grant;
	logic        e_lock, e_prot, e_err, e_wel, e_reset_cmd_enable, g;
	logic [23:0] v;
	logic [7:0]  rd_op = `FSR_OP_READ_STATUS;
	int          n;
	int          fails = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	always #12.5 clk_sys = ~clk_sys;

	flash_status_register u_flash_status_register (
		.clk_sys, .nrst, .sclk_pin(sclk), .cs_n_pin(cs_n), .si_pin(si), .wp_n_pin,
		.so_out, .so_oe_n, .core_busy, .core_op_done, .core_op_fail, .core_op_abort,
		.core_hold_abort, .core_dev_reset, .opcode_out, .opcode_valid, .write_enable_latch,
		.array_protect, .protection_lock, .reset_cmd_enable, .array_write_ok, .dev_reset_grant
	);
	fsr_host_model u_fsr_host_model (.clk_sys, .sclk, .cs_n, .si, .so(so_out), .so_oe_n);

	// ----------
	// Tasks
	// ----------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One frame of nb bits: opcode, then dat repeated; bits 8..31 captured
	task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input int nb,
		output logic [23:0] q);
		logic r;
		q = 24'h0;
		u_fsr_host_model.sel();
		for (int i = 0; i < nb; i++) begin
			u_fsr_host_model.xbit(i < 8 ? op[7 - i] : dat[7 - i % 8], r);
			if (i >= 8 && i < 32) q[31 - i] = r;
		end
		u_fsr_host_model.desel();
	endtask

	task automatic wr(input logic [7:0] op, input logic [7:0] dat, input int nb);
		cmd(`FSR_OP_WRITE_ENABLE, 8'h00, 8, v);
		cmd(op, dat, nb, v);
	endtask

	task automatic chk_stat();
		logic [7:0] b1;
		b1 = {e_lock, 1'b0, e_err, wp_n_pin, 1'b0, e_prot, e_wel, core_busy};
		cmd(`FSR_OP_READ_STATUS, 8'h00, 32, v);
		check(v[23:16], b1);
		check(v[15:8], {3'h0, e_reset_cmd_enable, 3'h0, core_busy});
		check(v[7:0], b1);
		check({7'h0, so_oe_n}, 8'h01);
		check({3'h0, write_enable_latch, array_protect, protection_lock, reset_cmd_enable,
			array_write_ok}, {3'h0, e_wel, e_prot, e_lock, e_reset_cmd_enable, e_wel & ~e_prot});
	endtask

	task automatic pulse(input logic [3:0] p);
		{core_dev_reset, core_hold_abort, core_op_abort, core_op_done} = p;
		#1 g = dev_reset_grant;
		@(posedge clk_sys);
		#1 {core_dev_reset, core_hold_abort, core_op_abort, core_op_done} = 4'h0;
	endtask

	// Keep clocking status bytes until the busy bit reads 0, at most 40 bytes
	task automatic poll(output int cnt);
		logic [7:0] b;
		logic       r;
		u_fsr_host_model.sel();
		for (int i = 0; i < 8; i++) u_fsr_host_model.xbit(rd_op[7 - i], r);
		cnt = 0;
		do begin
			for (int i = 0; i < 8; i++) u_fsr_host_model.xbit(1'b0, b[7 - i]);
			cnt++;
		end while (b[0] !== 1'b0 && cnt < 40);
		u_fsr_host_model.desel();
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			$display("MISMATCH t=%0t run too long", $time);
			wrap_up();
		end
	end

	// ----------
	// Sequence
	// ----------
	initial begin
		nrst = 1'b0;
		wp_n_pin = 1'b1;
		{core_busy, core_op_fail} = 2'b00;
		{core_dev_reset, core_hold_abort, core_op_abort, core_op_done} = 4'h0;
		{e_lock, e_prot, e_err, e_wel, e_reset_cmd_enable} = 5'h00;
		repeat (20) @(posedge clk_sys);
		#1 nrst = 1'b1;
		chk_stat();
		cmd(`FSR_OP_READ_STATUS, 8'h00, 13, v);
		check({7'h0, so_oe_n}, 8'h01);
		$display("test reset done");
		cmd(`FSR_OP_WRITE_STATUS, 8'h84, 16, v);
		chk_stat();
		cmd(`FSR_OP_WRITE_ENABLE, 8'h00, 8, v);
		e_wel = 1'b1;
		cmd(8'hab, 8'h00, 8, v);
		cmd(`FSR_OP_WRITE_STATUS, 8'h00, 5, v);
		chk_stat();
		cmd(`FSR_OP_WRITE_DISABLE, 8'h00, 8, v);
		e_wel = 1'b0;
		chk_stat();
		$display("test latch done");
		wr(`FSR_OP_WRITE_STATUS, 8'hff, 24);
		{e_lock, e_prot} = 2'b11;
		chk_stat();
		wr(`FSR_OP_WRITE_STATUS, 8'h00, 13);
		chk_stat();
		wp_n_pin = 1'b0;
		wr(`FSR_OP_WRITE_STATUS, 8'h00, 16);
		chk_stat();
		wr(`FSR_OP_WRITE_STATUS, 8'h80, 16);
		chk_stat();
		wp_n_pin = 1'b1;
		wr(`FSR_OP_WRITE_STATUS, 8'h00, 16);
		{e_lock, e_prot} = 2'b00;
		chk_stat();
		wp_n_pin = 1'b0;
		wr(`FSR_OP_WRITE_STATUS, 8'h84, 16);
		{e_lock, e_prot} = 2'b11;
		chk_stat();
		wp_n_pin = 1'b1;
		$display("test status write done");
		cmd(`FSR_OP_WRITE_ENABLE, 8'h00, 8, v);
		e_wel = 1'b1;
		pulse(4'h8);
		check({7'h0, g}, 8'h00);
		chk_stat();
		wr(`FSR_OP_WRITE_STATUS2, 8'h10, 16);
		cmd(`FSR_OP_WRITE_ENABLE, 8'h00, 8, v);
		e_reset_cmd_enable = 1'b1;
		pulse(4'h8);
		check({7'h0, g}, 8'h01);
		e_wel = 1'b0;
		chk_stat();
		wr(`FSR_OP_WRITE_STATUS2, 8'hef, 16);
		e_reset_cmd_enable = 1'b0;
		chk_stat();
		$display("test reset enable done");
		{core_busy, core_op_fail} = 2'b11;
		cmd(`FSR_OP_WRITE_ENABLE, 8'h00, 8, v);
		e_wel = 1'b1;
		chk_stat();
		pulse(4'h1);
		{e_err, e_wel} = 2'b10;
		chk_stat();
		cmd(`FSR_OP_WRITE_ENABLE, 8'h00, 8, v);
		pulse(4'h2);
		chk_stat();
		cmd(`FSR_OP_WRITE_ENABLE, 8'h00, 8, v);
		pulse(4'h4);
		chk_stat();
		core_op_fail = 1'b0;
		pulse(4'h1);
		e_err = 1'b0;
		chk_stat();
		fork
			begin
				repeat (400) @(posedge clk_sys);
				#1 core_busy = 1'b0;
			end
			poll(n);
		join
		check({7'h0, n >= 5 && n < 9}, 8'h01);
		chk_stat();
		$display("test engine done");
		wrap_up();
	end
endmodule
